/* File: logic/cmp_regs_map.svh */
// Register map of the second comparator's control block: offsets,
// field positions, reset values and widths as macros.
// Assumes an 8-bit special-function-register bus with byte addresses.
`ifndef CMP_REGS_MAP_SVH
`define CMP_REGS_MAP_SVH

`define CMP_CTRL_ADDR 8'h9a
`define CMP_MODE_ADDR 8'h9c
`define CMP_INSEL_ADDR 8'h9f

`define CMP_CTRL_RESET 8'h00
`define CMP_MODE_RESET 8'h02
`define CMP_INSEL_RESET 8'h00

`define CMP_EN_BIT 7
`define CMP_OUT_BIT 6
`define CMP_RISE_BIT 5
`define CMP_FALL_BIT 4
`define CMP_HYP_LSB 2
`define CMP_HYN_LSB 0

`define CMP_NSEL_LSB 4
`define CMP_PSEL_LSB 0

`define CMP_RIE_BIT 5
`define CMP_FIE_BIT 4
`define CMP_MODE_LSB 0

`define CMP_FIELD_W 2
`define CMP_DATA_W 8

`endif

/* File: logic/cmp_regs_pkg.sv */
// Types shared by the comparator control block and its synchroniser.
// Assumes the map header supplies all numeric positions and resets.
`include "cmp_regs_map.svh"

package cmp_regs_pkg;

  typedef logic [`CMP_DATA_W-1:0] byte_type;

  // Hysteresis amount, same coding on both sides of the threshold
  typedef enum logic [`CMP_FIELD_W-1:0] {
    HYST_OFF = 2'h0,
    HYST_5MV = 2'h1,
    HYST_10MV = 2'h2,
    HYST_20MV = 2'h3
  } hyst_type;

  // Response time against supply current
  typedef enum logic [`CMP_FIELD_W-1:0] {
    RESP_FASTEST = 2'h0,
    RESP_MODE1 = 2'h1,
    RESP_MODE2 = 2'h2,
    RESP_LOWEST_POWER = 2'h3
  } resp_mode_type;

  // Pin choice for either comparator input, one pin per code
  typedef logic [`CMP_FIELD_W-1:0] pin_sel_type;

endpackage : cmp_regs_pkg

/* File: logic/cmp_link_if.sv */
// Carrier between the register bank and the output synchroniser.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps

interface cmp_link_if;
  logic rawOut;
  logic enable;
  logic level;
  logic risePulse;
  logic fallPulse;

  modport sync (
    input rawOut,
    input enable,
    output level,
    output risePulse,
    output fallPulse
  );

  modport regs (
    output rawOut,
    output enable,
    input level,
    input risePulse,
    input fallPulse
  );
endinterface : cmp_link_if

/* File: logic/cmp_edge_sync.sv */
// Brings the analog comparator output onto the system clock and
// turns its transitions into one-cycle edge pulses.
// Assumes the raw output is fully asynchronous to mclk.
`timescale 1ns/1ps

module cmp_edge_sync (
  input wire logic mclk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  cmp_link_if.sync link // Raw level in, clean level and edges out
);
  import cmp_regs_pkg::*;

  logic [2:0] syncReg;
  logic stableReg;
  logic levelReg;
  logic riseReg;
  logic fallReg;
  logic effLevel;

  ////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser; stage 0 feeds only stage 1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      syncReg <= 3'h0;
    end else begin
      syncReg <= {syncReg[1:0], link.rawOut};
    end
  end

  // Accept a new level only once stages 1 and 2 agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stableReg <= 1'b0;
    end else if (syncReg[1] == syncReg[2]) begin
      stableReg <= syncReg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Disabled comparator reads as low
  assign effLevel = link.enable & stableReg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      levelReg <= 1'b0;
      riseReg <= 1'b0;
      fallReg <= 1'b0;
    end else begin
      levelReg <= effLevel;
      riseReg <= effLevel & ~levelReg;
      fallReg <= ~effLevel & levelReg;
    end
  end

  assign link.level = levelReg;
  assign link.risePulse = riseReg;
  assign link.fallPulse = fallReg;

  ////////////////////////////////////////////////////////////////////
  // Pulse and new level land together; level may move again at once
  rise_once_a: assert property (@(posedge mclk) disable iff (!nrst)
    riseReg |-> levelReg ##1 !riseReg)
    else $error("rise pulse longer than one cycle");

  fall_once_a: assert property (@(posedge mclk) disable iff (!nrst)
    fallReg |-> !levelReg ##1 !fallReg)
    else $error("fall pulse longer than one cycle");

endmodule : cmp_edge_sync

/* File: logic/comparator_control_regs.sv */
// Control and status register bank for the second voltage comparator.
// Assumes a single-cycle SFR bus on mclk and an analog comparator
// whose raw output arrives asynchronously on cmpRawOut.
//
// Notes on behaviour
// - Control bit 7 switches comparator on/off.
// - Read-only bit 6 shows comparator output.
// - Bit 5 flags a rising output edge.
// - Bit 4 flags a falling output edge.
// - Bits 3-2 set positive hysteresis amount.
// - Bits 1-0 set negative hysteresis amount.
// - Input select bits 5-4 pick inverting pin.
// - Input select bits 1-0 pick non-inverting pin.
// - Unused input select bits read zero.
// - Mode bit 5 gates rising-edge interrupt.
// - Mode bit 4 gates falling-edge interrupt.
// - Mode bits 1-0 choose response time.
// - Edge flags hold until software writes 0.
// - Disabled comparator output drives low.
`timescale 1ns/1ps
`include "cmp_regs_map.svh"

module comparator_control_regs (
  input wire logic mclk, // System clock, 10 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [7:0] sfrAddr, // SFR byte address
  input wire cmp_regs_pkg::byte_type sfrWrData, // Write data
  input wire logic sfrWr, // Write strobe, one cycle
  input wire logic sfrRd, // Read strobe, one cycle
  output cmp_regs_pkg::byte_type sfrRdData, // Read data, next cycle
  input wire logic cmpRawOut, // Analog comparator output, async
  output logic cmpEnable, // Comparator power on
  output cmp_regs_pkg::hyst_type cmpPosHysteresis, // Positive hysteresis
  output cmp_regs_pkg::hyst_type cmpNegHysteresis, // Negative hysteresis
  output cmp_regs_pkg::pin_sel_type cmpNegInputSel, // Inverting pin
  output cmp_regs_pkg::pin_sel_type cmpPosInputSel, // Non-inverting pin
  output cmp_regs_pkg::resp_mode_type cmpResponseMode, // Response time
  output logic cmpIrq, // Interrupt request, level
  output logic cmpPinOut // Synchronous output for port routing
);
  import cmp_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Address decode shared by the write and read paths
  function automatic logic hitReg(input logic [7:0] addr,
                                  input logic [7:0] offset);
    hitReg = (addr == offset);
  endfunction : hitReg

  cmp_link_if link ();

  logic enable_reg;
  logic riseFlag_reg;
  logic fallFlag_reg;
  hyst_type posHyst_reg;
  hyst_type negHyst_reg;
  pin_sel_type negSel_reg;
  pin_sel_type posSel_reg;
  logic riseIe_reg;
  logic fallIe_reg;
  resp_mode_type respMode_reg;
  logic irq_reg;
  logic pinOut_reg;
  byte_type rdData_reg;
  byte_type rdData_next;
  logic riseFlag_next;
  logic fallFlag_next;
  logic wrCtrl;
  logic wrMode;
  logic wrInSel;

  assign wrCtrl = sfrWr & hitReg(sfrAddr, `CMP_CTRL_ADDR);
  assign wrMode = sfrWr & hitReg(sfrAddr, `CMP_MODE_ADDR);
  assign wrInSel = sfrWr & hitReg(sfrAddr, `CMP_INSEL_ADDR);

  ////////////////////////////////////////////////////////////////////
  // Synchroniser and edge detector
  assign link.rawOut = cmpRawOut;
  assign link.enable = enable_reg;

  cmp_edge_sync edgeSync (
    .mclk(mclk),
    .nrst(nrst),
    .link(link)
  );

  ////////////////////////////////////////////////////////////////////
  // Control register: enable and hysteresis
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      enable_reg <= 1'(`CMP_CTRL_RESET >> `CMP_EN_BIT);
      posHyst_reg <= HYST_OFF;
      negHyst_reg <= HYST_OFF;
    end else if (wrCtrl) begin
      enable_reg <= sfrWrData[`CMP_EN_BIT];
      posHyst_reg <= hyst_type'(sfrWrData[`CMP_HYP_LSB +: 2]);
      negHyst_reg <= hyst_type'(sfrWrData[`CMP_HYN_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky edge flags; a new edge wins over a clearing write
  always_comb begin
    riseFlag_next = riseFlag_reg;
    fallFlag_next = fallFlag_reg;
    if (wrCtrl) begin
      riseFlag_next = sfrWrData[`CMP_RISE_BIT];
      fallFlag_next = sfrWrData[`CMP_FALL_BIT];
    end
    if (link.risePulse) begin
      riseFlag_next = 1'b1;
    end
    if (link.fallPulse) begin
      fallFlag_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      riseFlag_reg <= 1'b0;
      fallFlag_reg <= 1'b0;
    end else begin
      riseFlag_reg <= riseFlag_next;
      fallFlag_reg <= fallFlag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Input select register; unused pairs are not stored at all
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      negSel_reg <= 2'h0;
      posSel_reg <= 2'h0;
    end else if (wrInSel) begin
      negSel_reg <= sfrWrData[`CMP_NSEL_LSB +: 2];
      posSel_reg <= sfrWrData[`CMP_PSEL_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode register: edge interrupt enables and response time
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      riseIe_reg <= 1'b0;
      fallIe_reg <= 1'b0;
      respMode_reg <= resp_mode_type'(2'(`CMP_MODE_RESET >> `CMP_MODE_LSB));
    end else if (wrMode) begin
      riseIe_reg <= sfrWrData[`CMP_RIE_BIT];
      fallIe_reg <= sfrWrData[`CMP_FIE_BIT];
      respMode_reg <= resp_mode_type'(sfrWrData[`CMP_MODE_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt request, one cycle behind the flags
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (riseFlag_reg & riseIe_reg) | (fallFlag_reg & fallIe_reg);
    end
  end

  // Routed output; gated by enable_reg too, as the synchroniser's level only drops one cycle after enable does
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinOut_reg <= 1'b0;
    end else begin
      pinOut_reg <= link.level & enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path; idle and unmapped reads return zero so the SFR
  // read bus can be OR-combined with other blocks
  always_comb begin
    rdData_next = 8'h00;
    if (sfrRd) begin
      if (hitReg(sfrAddr, `CMP_CTRL_ADDR)) begin
        rdData_next[`CMP_EN_BIT] = enable_reg;
        rdData_next[`CMP_OUT_BIT] = link.level;
        rdData_next[`CMP_RISE_BIT] = riseFlag_reg;
        rdData_next[`CMP_FALL_BIT] = fallFlag_reg;
        rdData_next[`CMP_HYP_LSB +: 2] = posHyst_reg;
        rdData_next[`CMP_HYN_LSB +: 2] = negHyst_reg;
      end else if (hitReg(sfrAddr, `CMP_INSEL_ADDR)) begin
        rdData_next[`CMP_NSEL_LSB +: 2] = negSel_reg;
        rdData_next[`CMP_PSEL_LSB +: 2] = posSel_reg;
      end else if (hitReg(sfrAddr, `CMP_MODE_ADDR)) begin
        rdData_next[`CMP_RIE_BIT] = riseIe_reg;
        rdData_next[`CMP_FIE_BIT] = fallIe_reg;
        rdData_next[`CMP_MODE_LSB +: 2] = respMode_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign sfrRdData = rdData_reg;
  assign cmpEnable = enable_reg;
  assign cmpPosHysteresis = posHyst_reg;
  assign cmpNegHysteresis = negHyst_reg;
  assign cmpNegInputSel = negSel_reg;
  assign cmpPosInputSel = posSel_reg;
  assign cmpResponseMode = respMode_reg;
  assign cmpIrq = irq_reg;
  assign cmpPinOut = pinOut_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks
  enable_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrCtrl |=> cmpEnable == $past(sfrWrData[7]))
    else $error("enable does not follow control write");

  out_state_a: assert property (@(posedge mclk) disable iff (!nrst)
    sfrRd && sfrAddr == `CMP_CTRL_ADDR |=> sfrRdData[6] == $past(link.level))
    else $error("output state bit wrong on read");

  rise_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    link.risePulse |=> riseFlag_reg)
    else $error("rising edge not flagged");

  fall_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    link.fallPulse |=> fallFlag_reg)
    else $error("falling edge not flagged");

  pos_hyst_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrCtrl |=> cmpPosHysteresis == $past(sfrWrData[3:2]))
    else $error("positive hysteresis not written");

  neg_hyst_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrCtrl |=> cmpNegHysteresis == $past(sfrWrData[1:0]))
    else $error("negative hysteresis not written");

  neg_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrInSel |=> cmpNegInputSel == $past(sfrWrData[5:4]))
    else $error("inverting select not written");

  pos_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrInSel |=> cmpPosInputSel == $past(sfrWrData[1:0]))
    else $error("non-inverting select not written");

  unused_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    sfrRd && sfrAddr == `CMP_INSEL_ADDR |=> sfrRdData[7:6] == 2'h0 && sfrRdData[3:2] == 2'h0)
    else $error("unused select bits not zero");

  rise_irq_a: assert property (@(posedge mclk) disable iff (!nrst)
    riseFlag_reg && riseIe_reg |=> cmpIrq)
    else $error("enabled rising flag gives no interrupt");

  fall_irq_a: assert property (@(posedge mclk) disable iff (!nrst)
    fallFlag_reg && fallIe_reg |=> cmpIrq)
    else $error("enabled falling flag gives no interrupt");

  resp_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrMode |=> cmpResponseMode == $past(sfrWrData[1:0]))
    else $error("response mode not written");

  flag_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    riseFlag_reg && !(wrCtrl && !sfrWrData[5]) |=> riseFlag_reg)
    else $error("rising flag lost without clear");

  off_low_a: assert property (@(posedge mclk) disable iff (!nrst)
    !cmpEnable |=> !cmpPinOut)
    else $error("routed output high while disabled");

  irq_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(riseFlag_reg && riseIe_reg) && !(fallFlag_reg && fallIe_reg) |=> !cmpIrq)
    else $error("interrupt without enabled flag");

  fall_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    fallFlag_reg && !(wrCtrl && !sfrWrData[`CMP_FALL_BIT]) |=> fallFlag_reg)
    else $error("falling flag lost without clear");

  rise_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrCtrl && !sfrWrData[`CMP_RISE_BIT] && !link.risePulse |=> !riseFlag_reg)
    else $error("rising flag not cleared by write");

  fall_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    wrCtrl && !sfrWrData[`CMP_FALL_BIT] && !link.fallPulse |=> !fallFlag_reg)
    else $error("falling flag not cleared by write");

  rd_idle_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    !sfrRd |=> sfrRdData == 8'h00)
    else $error("read data not zero outside a read");

  mode_unused_a: assert property (@(posedge mclk) disable iff (!nrst)
    sfrRd && sfrAddr == `CMP_MODE_ADDR |=> sfrRdData[7:6] == 2'h0 && sfrRdData[3:2] == 2'h0)
    else $error("unused mode bits not zero");

  pin_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
    cmpEnable |=> cmpPinOut == $past(link.level))
    else $error("routed output does not follow level");

  off_no_rise_a: assert property (@(posedge mclk) disable iff (!nrst)
    !cmpEnable |=> !link.risePulse)
    else $error("rising edge seen while disabled");

endmodule : comparator_control_regs

/* File: dv/analog_input_model.sv */
// Behavioural stand-in for the analog comparator and the port pins feeding it.
// Assumes the bench sets every pin voltage in millivolts as an integer.
`timescale 1ns/1ps

module analog_input_model (
  input wire logic enable, // Comparator power
  input wire logic [1:0] posSel, // Non-inverting pin choice
  input wire logic [1:0] negSel, // Inverting pin choice
  input int posMv [4], // Non-inverting pin voltages
  input int negMv [4], // Inverting pin voltages
  output logic rawOut // Raw decision, asynchronous
);
  // Unpowered comparator rests low; no hysteresis modelled, inputs kept far apart
  always_comb begin
    rawOut = enable && (posMv[posSel] > negMv[negSel]);
  end
endmodule : analog_input_model

/* File: dv/comparator_control_regs_bench.sv */
// Self-checking bench for the comparator control register bank.
// Assumes single-cycle read and write strobes driven at the falling edge.
`timescale 1ns/1ps
`include "cmp_regs_map.svh"

`define CHECK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end

module comparator_control_regs_bench;
  import cmp_regs_pkg::*;
  logic mclk;
  logic nrst;
  logic [7:0] sfrAddr;
  byte_type sfrWrData;
  logic sfrWr;
  logic sfrRd;
  byte_type sfrRdData;
  logic cmpRawOut;
  logic cmpEnable;
  hyst_type cmpPosHysteresis;
  hyst_type cmpNegHysteresis;
  pin_sel_type cmpNegInputSel;
  pin_sel_type cmpPosInputSel;
  resp_mode_type cmpResponseMode;
  logic cmpIrq;
  logic cmpPinOut;
  int posMv [4];
  int negMv [4];
  int fails = 0;
  int comparisons = 0;
  int i;

  ////////////////////////////////////////////////////////////////////////////
  comparator_control_regs u_dut (
    .mclk(mclk),
    .nrst(nrst),
    .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData),
    .sfrWr(sfrWr),
    .sfrRd(sfrRd),
    .sfrRdData(sfrRdData),
    .cmpRawOut(cmpRawOut),
    .cmpEnable(cmpEnable),
    .cmpPosHysteresis(cmpPosHysteresis),
    .cmpNegHysteresis(cmpNegHysteresis),
    .cmpNegInputSel(cmpNegInputSel),
    .cmpPosInputSel(cmpPosInputSel),
    .cmpResponseMode(cmpResponseMode),
    .cmpIrq(cmpIrq),
    .cmpPinOut(cmpPinOut)
  );

  analog_input_model u_analog (
    .enable(cmpEnable),
    .posSel(cmpPosInputSel),
    .negSel(cmpNegInputSel),
    .posMv(posMv),
    .negMv(negMv),
    .rawOut(cmpRawOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input byte_type d);
    @(negedge mclk);
    sfrWr = 1'b1;
    sfrAddr = a;
    sfrWrData = d;
    @(negedge mclk);
    sfrWr = 1'b0;
  endtask : wr

  // Read data stands one cycle only, so it is taken at the very next falling edge
  task automatic rd(input logic [7:0] a, input byte_type exp);
    @(negedge mclk);
    sfrRd = 1'b1;
    sfrAddr = a;
    @(negedge mclk);
    sfrRd = 1'b0;
    `CHECK("sfrRdData", exp, sfrRdData)
  endtask : rd

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_cycles

  task automatic complete_run();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Whole run needs under two hundred cycles; twenty times that is a hang
  initial begin
    repeat (4000) @(posedge mclk);
    fails++;
    complete_run();
  end

  initial begin
    nrst = 1'b0;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    for (i = 0; i < 4; i++) begin
      posMv[i] = 0;
      negMv[i] = 0;
    end
    wait_cycles(16);
    nrst = 1'b1;
    `CHECK("cmpResponseMode", 2'h2, cmpResponseMode)
    rd(`CMP_CTRL_ADDR, 8'h00);
    rd(`CMP_MODE_ADDR, 8'h02);
    rd(`CMP_INSEL_ADDR, 8'h00);
    rd(8'h9b, 8'h00);
    // Unused bits written as ones must read back zero
    for (i = 0; i < 4; i++) begin
      wr(`CMP_INSEL_ADDR, {2'b11, i[1:0], 2'b11, ~i[1:0]});
      `CHECK("cmpNegInputSel", i[1:0], cmpNegInputSel)
      `CHECK("cmpPosInputSel", ~i[1:0], cmpPosInputSel)
      rd(`CMP_INSEL_ADDR, {2'b00, i[1:0], 2'b00, ~i[1:0]});
      wr(`CMP_CTRL_ADDR, {4'h4, i[1:0], ~i[1:0]});
      `CHECK("cmpPosHysteresis", i[1:0], cmpPosHysteresis)
      `CHECK("cmpNegHysteresis", ~i[1:0], cmpNegHysteresis)
      rd(`CMP_CTRL_ADDR, {4'h0, i[1:0], ~i[1:0]});
      wr(`CMP_MODE_ADDR, {6'h33, i[1:0]});
      `CHECK("cmpResponseMode", i[1:0], cmpResponseMode)
      rd(`CMP_MODE_ADDR, {6'h00, i[1:0]});
    end
    // Rising edge on pin pair: positive pin 1, negative pin 2
    wr(`CMP_INSEL_ADDR, 8'h21);
    wr(`CMP_CTRL_ADDR, 8'h80);
    `CHECK("cmpEnable", 1'b1, cmpEnable)
    wait_cycles(8);
    wr(`CMP_CTRL_ADDR, 8'h80);
    posMv[1] = 100;
    negMv[2] = 50;
    wait_cycles(8);
    `CHECK("cmpPinOut", 1'b1, cmpPinOut)
    `CHECK("cmpIrq", 1'b0, cmpIrq)
    rd(`CMP_CTRL_ADDR, 8'he0);
    wr(`CMP_MODE_ADDR, 8'h20);
    wait_cycles(2);
    `CHECK("cmpIrq", 1'b1, cmpIrq)
    wait_cycles(20);
    rd(`CMP_CTRL_ADDR, 8'he0);
    wr(`CMP_CTRL_ADDR, 8'h80);
    wait_cycles(2);
    `CHECK("cmpIrq", 1'b0, cmpIrq)
    wait_cycles(10);
    rd(`CMP_CTRL_ADDR, 8'hc0);
    // Falling edge, first with its interrupt blocked
    negMv[2] = 150;
    wait_cycles(8);
    `CHECK("cmpPinOut", 1'b0, cmpPinOut)
    `CHECK("cmpIrq", 1'b0, cmpIrq)
    rd(`CMP_CTRL_ADDR, 8'h90);
    wr(`CMP_MODE_ADDR, 8'h10);
    wait_cycles(2);
    `CHECK("cmpIrq", 1'b1, cmpIrq)
    wr(`CMP_MODE_ADDR, 8'h00);
    wait_cycles(2);
    `CHECK("cmpIrq", 1'b0, cmpIrq)
    // Switching off with the output high
    wr(`CMP_CTRL_ADDR, 8'h80);
    negMv[2] = 50;
    wait_cycles(8);
    rd(`CMP_CTRL_ADDR, 8'he0);
    wr(`CMP_CTRL_ADDR, 8'h00);
    `CHECK("cmpEnable", 1'b0, cmpEnable)
    wait_cycles(8);
    `CHECK("cmpPinOut", 1'b0, cmpPinOut)
    rd(`CMP_CTRL_ADDR, 8'h10);
    complete_run();
  end
endmodule : comparator_control_regs_bench
